// ===== tcrc_map.svh
// Constants of the transponder CRC-16 generator: widths, values and counts
//------------------------------------------------------------------------------
`ifndef TCRC_MAP_SVH
`define TCRC_MAP_SVH
`define TCRC_WIDTH       16
`define TCRC_INIT        16'h3791
`define TCRC_POLY_REFL   16'h8408
`define TCRC_RESIDUE     16'h0000
`define TCRC_START_BYTE  8'h7E
`define TCRC_START_BITS  8
`define TCRC_DATA_BYTES  6
`define TCRC_ADDR_BYTES  1
`define TCRC_CNT_W       7
`endif

// ===== tcrc_pkg.sv
// Types shared by the transponder CRC-16 generator files
package tcrc_pkg;
	// Serial bit with its one-cycle bit strobe
	typedef struct packed {
		logic strobe;
		logic data;
	} tcrc_bit_s;

	// Seed choice: sel=0 default start value, sel=1 supplied value
	typedef struct packed {
		logic        sel;
		logic [15:0] value;
	} tcrc_seed_s;

	// Frame phases
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_RX    = 3'b001,
		ST_SKIP  = 3'b010,
		ST_ACC   = 3'b011,
		ST_SHIFT = 3'b100
	} tcrc_state_e;
endpackage : tcrc_pkg

// ===== tcrc_shift.sv
// Sixteen-cell serial CRC register with load, accumulate and plain shift modes
`timescale 1ns/1ps
`default_nettype none
`include "tcrc_map.svh"
module tcrc_shift #(
	parameter int WIDTH = `TCRC_WIDTH
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// Control
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_value,
	input  wire logic             step,
	input  wire logic             shift_only,
	input  wire logic             din,
	// State
	output var  logic [WIDTH-1:0] crc
);
	// The tap pattern is fixed at sixteen cells; other widths cannot be served
	generate
		if (WIDTH != 16)
			$error("tcrc_shift: only a sixteen-cell register is supported");
	endgenerate

	//--------------------------------------------------------------------------
	// Feedback network
	//--------------------------------------------------------------------------
	// Reflected form: cell 0 is the register output, so data goes LSB first
	wire             feedback = din ^ crc[0];
	wire [WIDTH-1:0] taps     = feedback ? WIDTH'(`TCRC_POLY_REFL) : '0;
	// Plain shift mode lets zeros in and leaves the taps out
	wire [WIDTH-1:0] next_crc = shift_only ? (crc >> 1)
	                                       : ((crc >> 1) ^ taps);

	//--------------------------------------------------------------------------
	// Register
	//--------------------------------------------------------------------------
	// Load beats step so a new frame never mixes with a stale bit
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			crc <= WIDTH'(`TCRC_INIT);
		else if (load)
			crc <= load_value;
		else if (step)
			crc <= next_crc;
	end
endmodule : tcrc_shift
`default_nettype wire

// ===== tcrc_core.sv
// Frame sequencer around the CRC-16 register for the LF write and read paths
`timescale 1ns/1ps
`default_nettype none
`include "tcrc_map.svh"
module tcrc_core #(
	parameter int START_BITS = `TCRC_START_BITS,
	parameter int DATA_BYTES = `TCRC_DATA_BYTES,
	parameter int ADDR_BYTES = `TCRC_ADDR_BYTES
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   reset,
	// Frame starts, write frame end and seed choice
	input  wire logic                   wr_start,
	input  wire logic                   wr_end,
	input  wire logic                   rd_start,
	input  wire tcrc_pkg::tcrc_seed_s   seed,
	// Receive path
	input  wire tcrc_pkg::tcrc_bit_s    rx_bit,
	// Transmit path
	input  wire tcrc_pkg::tcrc_bit_s    tx_bit,
	// Write check result
	output var  logic                   crc_ok,
	output var  logic                   result_valid,
	// Check word out
	output var  logic                   check_bit,
	output var  logic                   check_active,
	output var  logic                   read_done,
	output var  logic [15:0]            block_check_word
);
	// Last count of each phase; every phase counts from zero
	localparam int ACC_BITS = (DATA_BYTES + ADDR_BYTES) * 8;
	localparam logic [`TCRC_CNT_W-1:0] SKIP_LAST  = `TCRC_CNT_W'(START_BITS - 1);
	localparam logic [`TCRC_CNT_W-1:0] ACC_LAST   = `TCRC_CNT_W'(ACC_BITS - 1);
	localparam logic [`TCRC_CNT_W-1:0] SHIFT_LAST = `TCRC_CNT_W'(`TCRC_WIDTH - 1);

	// The bit counter is seven bits wide; larger frames cannot be counted
	generate
		if (START_BITS < 1 || START_BITS > 127 || ACC_BITS < 8 || ACC_BITS > 127)
			$error("tcrc_core: frame sizes out of range");
	endgenerate

	tcrc_pkg::tcrc_state_e         state;
	tcrc_pkg::tcrc_state_e         next_state;
	logic [`TCRC_CNT_W-1:0]        cnt;
	logic [`TCRC_CNT_W-1:0]        next_cnt;
	logic [15:0]                   crc;

	//--------------------------------------------------------------------------
	// Step selection
	//--------------------------------------------------------------------------
	wire in_rx    = (state == tcrc_pkg::ST_RX);
	wire in_skip  = (state == tcrc_pkg::ST_SKIP);
	wire in_acc   = (state == tcrc_pkg::ST_ACC);
	wire in_shift = (state == tcrc_pkg::ST_SHIFT);
	wire load     = wr_start | rd_start;
	wire [15:0] load_value = seed.sel ? seed.value : `TCRC_INIT;
	wire rx_step  = in_rx & rx_bit.strobe;
	// Transmit strobes drive every read phase; the bit counter runs on them alone
	wire tx_step  = (in_skip | in_acc | in_shift) & tx_bit.strobe;
	// The start byte counts bits but never reaches the register
	wire gen_step = rx_step | (tx_step & ~in_skip);
	// Each frame direction feeds the register from its own line
	wire gen_din  = in_rx ? rx_bit.data : tx_bit.data;
	// wr_end judges the register as it stood before this edge, so give it one
	// quiet cycle after the last check-word bit; a start in the same cycle wins
	wire frame_chk = in_rx & wr_end & ~load;
	wire skip_end  = in_skip & tx_step & (cnt == SKIP_LAST);
	wire acc_end   = in_acc & tx_step & (cnt == ACC_LAST);
	wire shift_end = in_shift & tx_step & (cnt == SHIFT_LAST);

	//--------------------------------------------------------------------------
	// Next state and bit count
	//--------------------------------------------------------------------------
	assign next_state = wr_start  ? tcrc_pkg::ST_RX    :
	                    rd_start  ? tcrc_pkg::ST_SKIP  :
	                    frame_chk ? tcrc_pkg::ST_IDLE  :
	                    skip_end  ? tcrc_pkg::ST_ACC   :
	                    acc_end   ? tcrc_pkg::ST_SHIFT :
	                    shift_end ? tcrc_pkg::ST_IDLE  : state;
	// Each phase counts from zero
	assign next_cnt = (load | skip_end | acc_end | shift_end) ? '0 :
	                  tx_step ? cnt + `TCRC_CNT_W'(1) : cnt;

	// One register serves both directions; the phase picks its input and mode
	tcrc_shift #(
		.WIDTH      (`TCRC_WIDTH)
	) u_shift (
		.clk        (clk),
		.reset      (reset),
		.load       (load),
		.load_value (load_value),
		.step       (gen_step),
		.shift_only (in_shift),
		.din        (gen_din),
		.crc        (crc)
	);

	//--------------------------------------------------------------------------
	// Sequencer registers
	//--------------------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= tcrc_pkg::ST_IDLE;
			cnt   <= '0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
		end
	end

	// Result and handshake flags; pulses last one cycle
	// check_active follows next_state so it rises as the first check bit stands
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			crc_ok       <= 1'b0;
			result_valid <= 1'b0;
			read_done    <= 1'b0;
			check_active <= 1'b0;
		end else begin
			if (frame_chk)
				crc_ok <= (crc == `TCRC_RESIDUE);
			else if (load)
				crc_ok <= 1'b0;
			result_valid <= frame_chk;
			read_done    <= shift_end;
			check_active <= (next_state == tcrc_pkg::ST_SHIFT);
		end
	end

	// Register cell 0 is the next check word bit, LSB first
	assign check_bit        = crc[0];
	assign block_check_word = crc;

	//--------------------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------------------
	// All checks run on the block clock and sleep while reset is high
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_seed_default: assert property (load && !seed.sel |=> crc == 16'h3791)
		else $error("default seed not loaded");
	a_seed_given: assert property (load && seed.sel |=> crc == $past(seed.value))
		else $error("supplied seed not loaded");
	a_hold_idle: assert property (!load && !gen_step |=> crc == $past(crc))
		else $error("register moved without a strobe");
	a_poly_step: assert property (!load && gen_step && !in_shift |=>
		crc == (($past(crc) >> 1) ^ (($past(crc[0]) ^ $past(gen_din)) ? 16'h8408 : 16'h0000)))
		else $error("CRC step wrong");
	a_rx_first: assert property (wr_start ##1 (rx_bit.strobe && !load) |=>
		crc == ((16'h3791 >> 1) ^ ((1'b1 ^ $past(rx_bit.data)) ? 16'h8408 : 16'h0000))
		|| $past(seed.sel, 2))
		else $error("first received bit not taken");
	a_ok_zero: assert property (frame_chk |=> result_valid && crc_ok == ($past(crc) == 16'h0000))
		else $error("residue check wrong");
	a_skip_start: assert property (in_skip && !load |=> crc == $past(crc))
		else $error("start byte reached the register");
	a_skip_len: assert property (rd_start && !wr_start ##1
		(tx_bit.strobe && !load)[*7] |=> in_skip)
		else $error("skip phase ended before eight bits");
	a_plain_shift: assert property (in_shift && tx_bit.strobe && !load |=>
		crc == ($past(crc) >> 1))
		else $error("check word not shifted plainly");
	a_word_end: assert property (shift_end && !load |=> read_done && !check_active
		&& state == tcrc_pkg::ST_IDLE)
		else $error("check word length wrong");

	//--------------------------------------------------------------------------
	// Write frame flags
	//--------------------------------------------------------------------------
	// The verdict pulse must not smear into a second cycle and be read twice
	a_result_pulse: assert property (result_valid |=> !result_valid)
		else $error("result pulse longer than one cycle");
	// A judged frame is over; the sequencer waits for the next start
	a_check_idle: assert property (frame_chk |=>
		state == tcrc_pkg::ST_IDLE && !check_active)
		else $error("sequencer busy after the residue test");
	// A new start withdraws the old verdict so it is never read for a new frame
	a_verdict_clear: assert property (load |=> !crc_ok && !result_valid)
		else $error("old verdict kept over a new start");
	// A frame end outside a write frame is refused
	a_stray_end: assert property (wr_end && !in_rx |=> !result_valid)
		else $error("frame end accepted outside a write frame");

	//--------------------------------------------------------------------------
	// Read phase checks
	//--------------------------------------------------------------------------
	// Check-word strobes since the last accumulate bit; counted apart from the
	// sequencer so that a fault in its own counter shows up in the length check
	logic [4:0] shift_seen;
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			shift_seen <= 5'h00;
		else if (load || acc_end)
			shift_seen <= 5'h00;
		else if (in_shift && tx_bit.strobe)
			shift_seen <= shift_seen + 5'h01;
	end

	// Eight start-byte strobes move the sequencer on to accumulation
	a_skip_done: assert property (rd_start && !wr_start ##1
		(tx_bit.strobe && !load)[*8] |=> in_acc)
		else $error("accumulation not begun after the start byte");
	// The last address bit hands over to the plain shift phase
	a_acc_done: assert property (acc_end && !load |=> in_shift && check_active)
		else $error("shift phase not entered after the address byte");
	// The check word keeps shifting until all sixteen bits are out
	a_shift_hold: assert property (in_shift && !shift_end && !load |=>
		in_shift && check_active)
		else $error("shift phase left early");
	a_word_len: assert property (read_done |-> shift_seen == 5'h10)
		else $error("check word not sixteen bits long");

	//--------------------------------------------------------------------------
	// Coverage
	//--------------------------------------------------------------------------
	c_write_good: cover property (frame_chk && crc == 16'h0000);
	c_write_bad:  cover property (frame_chk && crc != 16'h0000);
	c_read_done:  cover property (read_done);
	c_seed_given: cover property (rd_start && seed.sel);
	c_write_seed: cover property (wr_start && seed.sel);
endmodule : tcrc_core
`default_nettype wire

// ===== tcrc_interrogator.sv
// Interrogator model: builds write check words and judges read replies
`timescale 1ns/1ps
`default_nettype none
module tcrc_interrogator (
	// Clock
	input  wire logic                clk,
	// Bit stream toward the device
	output var  tcrc_pkg::tcrc_bit_s rx_bit
);
	logic [15:0] acc;

	initial begin
		rx_bit = '0;
		acc    = 16'h3791;
	end
	// Same seed as the device, loaded per frame
	task automatic seed_acc(input logic [15:0] s);
		acc = s;
	endtask : seed_acc
	// Reflected generator step, so cell 0 leads and bits go LSB first
	task automatic absorb(input logic d);
		acc = (acc >> 1) ^ ((acc[0] ^ d) ? 16'h8408 : 16'h0000);
	endtask : absorb
	// Bytes leave LSB first, back to back; the strobe stays up between bytes
	task automatic send_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			rx_bit = '{strobe: 1'b1, data: b[i]};
			absorb(b[i]);
			@(posedge clk);
			#1;
		end
	endtask : send_byte
	// Line goes quiet; data flips so no stale bit looks valid
	task automatic release_line();
		rx_bit = '{strobe: 1'b0, data: ~rx_bit.data};
	endtask : release_line
endmodule : tcrc_interrogator
`default_nettype wire

// ===== transponder_crc16_generator_tb.sv
// Self-checking bench for the CRC-16 frame sequencer
`timescale 1ns/1ps
`default_nettype none
module transponder_crc16_generator_tb;
	logic                 clk, reset, wr_start, wr_end, rd_start;
	tcrc_pkg::tcrc_seed_s seed;
	tcrc_pkg::tcrc_bit_s  rx_bit, tx_bit;
	logic                 crc_ok, result_valid, check_bit, check_active, read_done;
	logic [15:0]          block_check_word;
	int                   n_fail, n_checks, cycles;

	tcrc_core i_tcrc_core (.clk(clk), .reset(reset), .wr_start(wr_start), .wr_end(wr_end),
		.rd_start(rd_start), .seed(seed), .rx_bit(rx_bit), .tx_bit(tx_bit), .crc_ok(crc_ok),
		.result_valid(result_valid), .check_bit(check_bit), .check_active(check_active),
		.read_done(read_done), .block_check_word(block_check_word));
	tcrc_interrogator i_tcrc_interrogator (.clk(clk), .rx_bit(rx_bit));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	// Inputs always move 1 ns after the rising edge
	task automatic next_cycle();
		@(posedge clk);
		#1;
	endtask : next_cycle
	task automatic pulse_start(input logic rd, input logic sel, input logic [15:0] v);
		seed     = '{sel: sel, value: v};
		wr_start = ~rd;
		rd_start = rd;
		next_cycle();
		wr_start = 1'b0;
		rd_start = 1'b0;
	endtask : pulse_start
	task automatic tx_byte(input logic [7:0] b, input logic acc);
		for (int i = 0; i < 8; i++) begin
			tx_bit = '{strobe: 1'b1, data: b[i]};
			if (acc) i_tcrc_interrogator.absorb(b[i]);
			next_cycle();
		end
	endtask : tx_byte
	// Idle strobes after reset must not disturb the seed
	task automatic t_reset();
		check(block_check_word, 16'h3791, "reset seed");
		i_tcrc_interrogator.send_byte(8'h5A);
		i_tcrc_interrogator.release_line();
		check(block_check_word, 16'h3791, "idle strobes");
		wr_end = 1'b1;
		next_cycle();
		wr_end = 1'b0;
		check(result_valid, 1'b0, "stray frame end");
		$display("reset test done");
	endtask : t_reset
	task automatic t_write(input logic sel, input logic [15:0] s, input logic bad);
		logic [15:0] word;
		pulse_start(1'b0, sel, s);
		check(block_check_word, sel ? s : 16'h3791, "write seed");
		check(crc_ok, 1'b0, "verdict cleared");
		i_tcrc_interrogator.seed_acc(sel ? s : 16'h3791);
		for (int i = 0; i < 3; i++) i_tcrc_interrogator.send_byte(i[7:0] ^ 8'hC3);
		i_tcrc_interrogator.release_line();
		word = i_tcrc_interrogator.acc;
		check(block_check_word, word, "accumulated");
		repeat (3) next_cycle();
		check(block_check_word, word, "hold");
		word = bad ? word ^ 16'h0001 : word;
		i_tcrc_interrogator.send_byte(word[7:0]);
		i_tcrc_interrogator.send_byte(word[15:8]);
		i_tcrc_interrogator.release_line();
		wr_end = 1'b1;
		next_cycle();
		wr_end = 1'b0;
		check(result_valid, 1'b1, "result pulse");
		check(crc_ok, !bad, "residue");
		next_cycle();
		check(result_valid, 1'b0, "result pulse end");
		check(crc_ok, !bad, "verdict stands");
		$display("write test done sel %b bad %b", sel, bad);
	endtask : t_write
	task automatic t_read(input logic sel, input logic [15:0] s);
		logic [15:0] word;
		pulse_start(1'b1, sel, s);
		check(crc_ok, 1'b0, "verdict cleared on read");
		i_tcrc_interrogator.seed_acc(sel ? s : 16'h3791);
		tx_byte(8'h7E, 1'b0);
		check(block_check_word, sel ? s : 16'h3791, "start byte");
		for (int i = 0; i < 7; i++) tx_byte(i[7:0] ^ 8'h96, 1'b1);
		word = i_tcrc_interrogator.acc;
		check(check_active, 1'b1, "shift phase");
		check(block_check_word, word, "check word");
		for (int i = 0; i < 16; i++) begin
			check(check_bit, word[i], "bit order");
			i_tcrc_interrogator.absorb(check_bit);
			tx_bit = '{strobe: 1'b1, data: check_bit};
			next_cycle();
		end
		tx_bit = '{strobe: 1'b0, data: ~tx_bit.data};
		check(read_done, 1'b1, "read done");
		check(check_active, 1'b0, "shift ended");
		check(i_tcrc_interrogator.acc, 16'h0000, "reply residue");
		next_cycle();
		check(read_done, 1'b0, "read done pulse end");
		$display("read test done sel %b", sel);
	endtask : t_read
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : complete_run

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Hang guard: the whole run needs well under 1000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			complete_run();
		end
	end
	initial begin
		{reset, wr_start, wr_end, rd_start} = 4'b1000;
		seed     = '0;
		tx_bit   = '0;
		n_fail   = 0;
		n_checks = 0;
		cycles   = 0;
		repeat (5) @(posedge clk);
		#1;
		reset = 1'b0;
		t_reset();
		t_write(1'b0, 16'h0000, 1'b0);
		t_write(1'b0, 16'h0000, 1'b1);
		t_write(1'b1, 16'hBEEF, 1'b0);
		t_read(1'b0, 16'h0000);
		t_read(1'b1, 16'h1234);
		complete_run();
	end
endmodule : transponder_crc16_generator_tb
`default_nettype wire
